// ### drt_consts.svh
`ifndef DRT_CONSTS_SVH
`define DRT_CONSTS_SVH
// ----------------------------------------
// clocking
// ----------------------------------------
`define DRT_CLK_PS          5000
`define DRT_CK_DIV          2
`define DRT_CK_PS           (`DRT_CLK_PS * `DRT_CK_DIV)
`define DRT_CEIL(t)         (((t) + `DRT_CK_PS - 1) / `DRT_CK_PS)
`define DRT_FLOOR(t)        ((t) / `DRT_CK_PS)
// ----------------------------------------
// refresh
// ----------------------------------------
`define DRT_TREFI_PS        7812500
`define DRT_TREFI_HOT_PS    3906250
`define DRT_REF_OWED_MAX    9
`define DRT_REF_FORCE       8
`define DRT_TRFC_PS         110000
`define DRT_SLOW_TCK_PS     40000
// ----------------------------------------
// row and write timing
// ----------------------------------------
`define DRT_TRAS_PS         35000
`define DRT_TRCD_PS         13750
`define DRT_TRP_PS          13750
`define DRT_TWR_PS          15000
`define DRT_TWR_DLLOFF_PS   15000
`define DRT_TWR_DLLOFF_CK   4
`define DRT_WR_START_BL8    4
`define DRT_WR_START_BC4    2
// ----------------------------------------
// power-down, init and row hammer limit
// ----------------------------------------
`define DRT_TREFPDEN_CK     1
`define DRT_TXPDLL_PS       24000
`define DRT_TXP_PS          6000
`define DRT_TINIT_RST_PS    200000000
`define DRT_TINIT_CKE_PS    500000000
`define DRT_HAMMER_MAX      64
`endif

// ### drt_pkg.sv
package drt_pkg;
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA, CMD_REF
    } drt_cmd_t;
    typedef enum logic [3:0] {
        ST_RESET, ST_CKE_WAIT, ST_IDLE, ST_REF_WAIT, ST_PD, ST_PD_EXIT
    } drt_state_t;
endpackage

// ### drt_bank_if.sv
`timescale 1ns/1ps
interface drt_bank_if;
    logic       tick;
    logic       act;
    logic       rd;
    logic       wr;
    logic       pre;
    logic       ap;
    logic [7:0] wr_rec;
    logic       open;
    logic       act_ok;
    logic       col_ok;
    logic       pre_ok;
    modport ctrl  (output tick, act, rd, wr, pre, ap, wr_rec,
                   input open, act_ok, col_ok, pre_ok);
    modport timer (input tick, act, rd, wr, pre, ap, wr_rec,
                   output open, act_ok, col_ok, pre_ok);
endinterface

// ### drt_bank_timer.sv
`timescale 1ns/1ps
`include "drt_consts.svh"
module drt_bank_timer (
    input  wire logic   clk,
    input  wire logic   rst_n,
    drt_bank_if.timer   bif
);
    localparam logic [7:0] TRAS_CK = 8'(`DRT_CEIL(`DRT_TRAS_PS));
    localparam logic [7:0] TRCD_CK = 8'(`DRT_CEIL(`DRT_TRCD_PS));
    localparam logic [7:0] TRP_CK  = 8'(`DRT_CEIL(`DRT_TRP_PS));

    logic       open_reg;
    logic       ap_pend_reg;
    logic [7:0] ras_reg;
    logic [7:0] rcd_reg;
    logic [7:0] rp_reg;
    logic [7:0] wr_reg;
    logic [7:0] since_act_reg;
    logic       auto_close;

    // the device closes the row itself only after tRAS and write recovery
    assign auto_close = ap_pend_reg && ras_reg == 8'h00 && wr_reg == 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            open_reg    <= 1'b0;
            ap_pend_reg <= 1'b0;
            ras_reg     <= 8'h00;
            rcd_reg     <= 8'h00;
            rp_reg      <= 8'h00;
            wr_reg      <= 8'h00;
        end else if (bif.tick) begin
            ras_reg <= (ras_reg != 8'h00) ? ras_reg - 8'h01 : 8'h00;
            rcd_reg <= (rcd_reg != 8'h00) ? rcd_reg - 8'h01 : 8'h00;
            rp_reg  <= (rp_reg != 8'h00) ? rp_reg - 8'h01 : 8'h00;
            wr_reg  <= (wr_reg != 8'h00) ? wr_reg - 8'h01 : 8'h00;
            if (bif.act) begin
                open_reg <= 1'b1;
                ras_reg  <= TRAS_CK;
                rcd_reg  <= TRCD_CK;
            end
            if (bif.wr) begin
                wr_reg <= bif.wr_rec;
            end
            if ((bif.wr || bif.rd) && bif.ap) begin
                ap_pend_reg <= 1'b1;
            end
            if ((bif.pre && open_reg) || auto_close) begin
                open_reg    <= 1'b0;
                ap_pend_reg <= 1'b0;
                rp_reg      <= TRP_CK;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_act_reg <= 8'h00;
        end else if (bif.tick) begin
            if (bif.act) begin
                since_act_reg <= 8'h00;
            end else if (since_act_reg != 8'hff) begin
                since_act_reg <= since_act_reg + 8'h01;
            end
        end
    end

    assign bif.open   = open_reg;
    assign bif.act_ok = !open_reg && rp_reg == 8'h00;
    assign bif.col_ok = open_reg && rcd_reg == 8'h00 && !ap_pend_reg;
    assign bif.pre_ok = !open_reg || (ras_reg == 8'h00 && wr_reg == 8'h00 && !ap_pend_reg);

    AST_PRE_AFTER_RAS: assert property (@(posedge clk) disable iff (!rst_n)
        (bif.pre && bif.tick && open_reg) |-> since_act_reg >= TRAS_CK - 8'h01)
        else $error("precharge before row active time");
    AST_AP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(open_reg) |-> $past(since_act_reg) >= TRAS_CK - 8'h01)
        else $error("row closed before row active time");
    AST_WR_RECOVERY: assert property (@(posedge clk) disable iff (!rst_n)
        (bif.wr && bif.tick) |=> (!bif.pre_ok || !open_reg) [*2])
        else $error("precharge allowed during write recovery");
endmodule

// ### drt_ctrl.sv
`timescale 1ns/1ps
`include "drt_consts.svh"
// Notes on behaviour
// - with DLL off, write recovery is the larger of 4 CK and 15 ns.
// - write recovery starts WL+4 for BL8/on-the-fly BC4, WL+2 for fixed BC4.
// - up to 85 C, one refresh every 7.8125 us on average.
// - never more than 70.3 us without nine refreshes issued; under traffic none goes out until eight are owed.
// - above 85 C the refresh interval is halved.
// - CKE low after refresh only once tREFPDEN and tXPDLL have passed.
// - at least one NOP between consecutive refresh commands.
// - below 25 MHz, each refresh is followed by precharge all.
// - spread accesses over rows; flag heavy repeated use of one row.
// - hold the memory reset low from power-up until init proceeds.
// - round minimum limits up and maximum limits down to whole cycles.
module drt_ctrl #(
    parameter int ROW_W       = 14,
    parameter int INIT_RST_CK = `DRT_CEIL(`DRT_TINIT_RST_PS),
    parameter int INIT_CKE_CK = `DRT_CEIL(`DRT_TINIT_CKE_PS),
    parameter int TRFC_PS     = `DRT_TRFC_PS
) (
    input  wire logic             CLK,
    input  wire logic             RST_N,
    input  wire logic             REQ_VALID,
    input  drt_pkg::drt_cmd_t     REQ_CMD,
    input  wire logic [2:0]       REQ_BANK,
    input  wire logic [ROW_W-1:0] REQ_ROW,
    input  wire logic [9:0]       REQ_COL,
    input  wire logic             REQ_AP,
    output logic                  REQ_ACK,
    input  wire logic             TEMP_HOT,
    input  wire logic             DLL_OFF,
    input  wire logic             BC4_FIXED,
    input  wire logic [3:0]       CWL,
    input  wire logic             PD_REQ,
    output logic                  DDR_CK,
    output logic                  DDR_CK_N,
    output logic                  DDR_CKE,
    output logic                  DDR_RESET_N,
    output logic                  DDR_CS_N,
    output logic                  DDR_RAS_N,
    output logic                  DDR_CAS_N,
    output logic                  DDR_WE_N,
    output logic [2:0]            DDR_BA,
    output logic [ROW_W-1:0]      DDR_ADDR,
    output logic [3:0]            REF_OWED,
    output logic                  ROW_HOT,
    output logic                  INIT_DONE
);
    import drt_pkg::*;

    // ----------------------------------------
    // derived cycle counts
    // ----------------------------------------
    localparam logic [15:0] REFI_CK     = 16'(`DRT_FLOOR(`DRT_TREFI_PS));
    localparam logic [15:0] REFI_HOT_CK = 16'(`DRT_FLOOR(`DRT_TREFI_HOT_PS));
    localparam int          TRFC_RAW    = `DRT_CEIL(TRFC_PS);
    // a wait of two ticks always leaves a NOP slot, even with tCK above tRFC
    localparam logic [15:0] TRFC_CK     = 16'((TRFC_RAW < 2) ? 2 : TRFC_RAW);
    localparam int          TXPDLL_RAW  = `DRT_CEIL(`DRT_TXPDLL_PS);
    localparam logic [15:0] PDEN_CK     = 16'((TXPDLL_RAW > `DRT_TREFPDEN_CK) ?
                                              TXPDLL_RAW : `DRT_TREFPDEN_CK);
    localparam logic [15:0] TXP_CK      = 16'(`DRT_CEIL(`DRT_TXP_PS));
    localparam int          TWR_OFF_RAW = `DRT_CEIL(`DRT_TWR_DLLOFF_PS);
    localparam logic [7:0]  TWR_OFF_CK  = 8'((TWR_OFF_RAW > `DRT_TWR_DLLOFF_CK) ?
                                             TWR_OFF_RAW : `DRT_TWR_DLLOFF_CK);
    localparam logic [7:0]  TWR_CK      = 8'(`DRT_CEIL(`DRT_TWR_PS));
    localparam logic        SLOW_CK     = (`DRT_CK_PS > `DRT_SLOW_TCK_PS);
    localparam logic [3:0]  OWED_MAX    = 4'(`DRT_REF_OWED_MAX);
    localparam logic [3:0]  OWED_FORCE  = 4'(`DRT_REF_FORCE);
    localparam logic [7:0]  HAMMER_MAX  = 8'(`DRT_HAMMER_MAX);

    // ----------------------------------------
    // link clock divider and input sync
    // ----------------------------------------
    logic ck_reg;
    logic tick;
    logic hot_meta_reg;
    logic hot_reg;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ck_reg   <= 1'b0;
            DDR_CK   <= 1'b0;
            DDR_CK_N <= 1'b1;
        end else begin
            ck_reg   <= ~ck_reg;
            DDR_CK   <= ~ck_reg;
            DDR_CK_N <= ck_reg;
        end
    end
    // pins change as CK falls, so the device sees them settled at the rise
    assign tick = ck_reg;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hot_meta_reg <= 1'b0;
            hot_reg      <= 1'b0;
        end else begin
            hot_meta_reg <= TEMP_HOT;
            hot_reg      <= hot_meta_reg;
        end
    end

    // ----------------------------------------
    // bank timers
    // ----------------------------------------
    drt_bank_if bif [8] ();
    logic [7:0] open_v;
    logic [7:0] act_ok_v;
    logic [7:0] col_ok_v;
    logic [7:0] pre_ok_v;
    logic [7:0] wr_rec;
    drt_cmd_t   cmd_c;
    logic [2:0] bank_c;

    // write recovery window measured from the write command
    assign wr_rec = 8'({4'h0, CWL}) + (BC4_FIXED ? 8'(`DRT_WR_START_BC4)
                  : 8'(`DRT_WR_START_BL8)) + (DLL_OFF ? TWR_OFF_CK : TWR_CK);

    for (genvar b = 0; b < 8; b++) begin : g_bank
        assign bif[b].tick   = tick;
        assign bif[b].act    = cmd_c == CMD_ACT && bank_c == 3'(b);
        assign bif[b].rd     = cmd_c == CMD_RD && bank_c == 3'(b);
        assign bif[b].wr     = cmd_c == CMD_WR && bank_c == 3'(b);
        assign bif[b].pre    = cmd_c == CMD_PREA || (cmd_c == CMD_PRE && bank_c == 3'(b));
        assign bif[b].ap     = REQ_AP;
        assign bif[b].wr_rec = wr_rec;
        assign open_v[b]     = bif[b].open;
        assign act_ok_v[b]   = bif[b].act_ok;
        assign col_ok_v[b]   = bif[b].col_ok;
        assign pre_ok_v[b]   = bif[b].pre_ok;
        drt_bank_timer u_timer (
            .clk   (CLK),
            .rst_n (RST_N),
            .bif   (bif[b])
        );
    end

    // ----------------------------------------
    // command scheduler
    // ----------------------------------------
    drt_state_t state_reg;
    drt_state_t state_next;
    logic [15:0] wait_reg;
    logic [15:0] wait_next;
    logic [15:0] refi_reg;
    logic [15:0] pden_reg;
    logic [3:0]  owed_reg;
    logic        cke_c;
    logic        ack_c;
    logic        req_ok;
    logic        ref_due;
    logic        ref_inc;
    logic        ref_dec;

    always_comb begin
        case (REQ_CMD)
            CMD_ACT: req_ok = act_ok_v[REQ_BANK];
            CMD_RD:  req_ok = col_ok_v[REQ_BANK];
            CMD_WR:  req_ok = col_ok_v[REQ_BANK];
            CMD_PRE: req_ok = pre_ok_v[REQ_BANK];
            default: req_ok = 1'b0;
        endcase
    end

    // once eight are owed, traffic stops until a refresh goes out
    assign ref_due = owed_reg != 4'h0 && (owed_reg >= OWED_FORCE || !REQ_VALID);

    always_comb begin
        state_next = state_reg;
        wait_next  = (wait_reg != 16'h0000) ? wait_reg - 16'h0001 : 16'h0000;
        cmd_c      = CMD_NOP;
        bank_c     = REQ_BANK;
        cke_c      = DDR_CKE;
        ack_c      = 1'b0;
        case (state_reg)
            ST_RESET: begin
                if (wait_reg == 16'h0000) begin
                    state_next = ST_CKE_WAIT;
                    wait_next  = 16'(INIT_CKE_CK);
                end
            end
            ST_CKE_WAIT: begin
                if (wait_reg == 16'h0000) begin
                    cke_c      = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (ref_due) begin
                    if (open_v == 8'h00 && &act_ok_v) begin
                        cmd_c      = CMD_REF;
                        state_next = ST_REF_WAIT;
                        wait_next  = TRFC_CK - 16'h0001;
                    end else if (&pre_ok_v) begin
                        cmd_c = CMD_PREA;
                    end
                end else if (REQ_VALID && req_ok) begin
                    cmd_c = REQ_CMD;
                    ack_c = 1'b1;
                end else if (PD_REQ && owed_reg == 4'h0 && open_v == 8'h00
                             && pden_reg == 16'h0000) begin
                    cke_c      = 1'b0;
                    state_next = ST_PD;
                end
            end
            ST_REF_WAIT: begin
                if (wait_reg == 16'h0000) begin
                    state_next = ST_IDLE;
                    if (SLOW_CK) begin
                        cmd_c = CMD_PREA;
                    end
                end
            end
            ST_PD: begin
                if (!PD_REQ || owed_reg != 4'h0) begin
                    cke_c      = 1'b1;
                    state_next = ST_PD_EXIT;
                    wait_next  = TXP_CK;
                end
            end
            ST_PD_EXIT: begin
                if (wait_reg == 16'h0000) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
    end

    // the memory reset stays low from our own reset until the INIT_RST_CK wait ends
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg   <= ST_RESET;
            wait_reg    <= 16'(INIT_RST_CK);
            DDR_RESET_N <= 1'b0;
            DDR_CKE     <= 1'b0;
            INIT_DONE   <= 1'b0;
        end else if (tick) begin
            state_reg   <= state_next;
            wait_reg    <= wait_next;
            DDR_RESET_N <= state_next != ST_RESET;
            DDR_CKE     <= cke_c;
            INIT_DONE   <= state_next != ST_RESET && state_next != ST_CKE_WAIT;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            DDR_CS_N  <= 1'b1;
            DDR_RAS_N <= 1'b1;
            DDR_CAS_N <= 1'b1;
            DDR_WE_N  <= 1'b1;
            DDR_BA    <= 3'h0;
            DDR_ADDR  <= '0;
        end else if (tick) begin
            DDR_CS_N  <= cmd_c == CMD_NOP;
            DDR_RAS_N <= !(cmd_c inside {CMD_ACT, CMD_PRE, CMD_PREA, CMD_REF});
            DDR_CAS_N <= !(cmd_c inside {CMD_RD, CMD_WR, CMD_REF});
            DDR_WE_N  <= !(cmd_c inside {CMD_WR, CMD_PRE, CMD_PREA});
            DDR_BA    <= bank_c;
            case (cmd_c)
                CMD_ACT:  DDR_ADDR <= REQ_ROW;
                CMD_RD:   DDR_ADDR <= ROW_W'({REQ_AP, REQ_COL});
                CMD_WR:   DDR_ADDR <= ROW_W'({REQ_AP, REQ_COL});
                CMD_PREA: DDR_ADDR <= ROW_W'(11'h400);
                default:  DDR_ADDR <= '0;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            REQ_ACK <= 1'b0;
        end else begin
            REQ_ACK <= tick && ack_c;
        end
    end

    // ----------------------------------------
    // refresh accounting
    // ----------------------------------------
    assign ref_inc = tick && INIT_DONE && refi_reg == 16'h0000;
    assign ref_dec = tick && cmd_c == CMD_REF;

    // a temperature change only re-times the running or next interval, owed stays
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            refi_reg <= REFI_CK;
        end else if (tick && INIT_DONE) begin
            if (refi_reg == 16'h0000) begin
                refi_reg <= (hot_reg ? REFI_HOT_CK : REFI_CK) - 16'h0001;
            end else if (hot_reg && refi_reg >= REFI_HOT_CK) begin
                refi_reg <= REFI_HOT_CK - 16'h0001;
            end else begin
                refi_reg <= refi_reg - 16'h0001;
            end
        end
    end

    // an interval expiring in the same tick as a refresh is still counted
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            owed_reg <= 4'h0;
        end else if (ref_inc && !ref_dec) begin
            owed_reg <= (owed_reg < OWED_MAX) ? owed_reg + 4'h1 : owed_reg;
        end else if (ref_dec && !ref_inc) begin
            owed_reg <= owed_reg - 4'h1;
        end
    end
    assign REF_OWED = owed_reg;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pden_reg <= 16'h0000;
        end else if (tick) begin
            if (cmd_c == CMD_REF) begin
                pden_reg <= PDEN_CK + TRFC_CK;
            end else if (pden_reg != 16'h0000) begin
                pden_reg <= pden_reg - 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // row use monitor
    // ----------------------------------------
    logic [ROW_W+2:0] last_act_reg;
    logic [7:0]       hammer_reg;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            last_act_reg <= '0;
            hammer_reg   <= 8'h00;
            ROW_HOT      <= 1'b0;
        end else if (tick && cmd_c == CMD_ACT) begin
            last_act_reg <= {REQ_BANK, REQ_ROW};
            if (last_act_reg == {REQ_BANK, REQ_ROW}) begin
                hammer_reg <= (hammer_reg != 8'hff) ? hammer_reg + 8'h01 : hammer_reg;
                // counter holds repeats, so the last allowed activation sees max minus two
                ROW_HOT    <= hammer_reg >= HAMMER_MAX - 8'h02;
            end else begin
                hammer_reg <= 8'h00;
                ROW_HOT    <= 1'b0;
            end
        end
    end

    AST_OWED_BOUND: assert property (@(posedge CLK) disable iff (!RST_N)
        owed_reg <= OWED_MAX)
        else $error("refresh debt above nine");
    AST_REF_NOP: assert property (@(posedge CLK) disable iff (!RST_N)
        (tick && cmd_c == CMD_REF) |=> ##1 !(tick && cmd_c == CMD_REF) ##1 (cmd_c != CMD_REF))
        else $error("back to back refresh");
    AST_REF_INTERVAL: assert property (@(posedge CLK) disable iff (!RST_N)
        hot_reg && INIT_DONE |-> ##2 refi_reg < REFI_HOT_CK)
        else $error("hot interval not applied");
    AST_CKE_AFTER_REF: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(DDR_CKE) && INIT_DONE |-> $past(pden_reg, 2) == 16'h0000)
        else $error("power-down too soon after refresh");
    AST_RESET_HELD: assert property (@(posedge CLK) disable iff (!RST_N)
        state_reg == ST_RESET |-> !DDR_RESET_N && !DDR_CKE)
        else $error("memory reset released early");
    AST_DLLOFF_TWR: assert property (@(posedge CLK) disable iff (!RST_N)
        DLL_OFF |-> wr_rec >= 8'({4'h0, CWL}) + 8'(`DRT_WR_START_BC4) + 8'h04)
        else $error("dll-off write recovery short");
    AST_TEMP_KEEP: assert property (@(posedge CLK) disable iff (!RST_N)
        $changed(hot_reg) && !ref_dec |=> owed_reg >= $past(owed_reg))
        else $error("owed refresh lost on temperature change");
    AST_SLOW_PREA: assert property (@(posedge CLK) disable iff (!RST_N)
        (tick && state_reg == ST_REF_WAIT && wait_reg == 16'h0000)
        |-> (cmd_c == CMD_PREA) == SLOW_CK)
        else $error("slow clock refresh not followed by precharge all");
endmodule

// ### drt_dev_model.sv
`timescale 1ns/1ps
module drt_dev_model
    import drt_pkg::*;
(
    input  wire logic       ck,
    input  wire logic       cs_n,
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic [2:0] ba,
    input  wire logic       a10,
    output drt_cmd_t        cmd,
    output time             ref_t,
    output int              n_viol
);
    // ----------------------------------------
    // command decode and own-precharge timing
    // ----------------------------------------
    time act_t  [8] = '{default: 0};
    time free_t [8] = '{default: 0};
    initial begin
        cmd = CMD_NOP;
        ref_t = 0;
        n_viol = 0;
    end
    always @(posedge ck) begin
        cmd = CMD_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'b011:  cmd = CMD_ACT;
                3'b101:  cmd = CMD_RD;
                3'b100:  cmd = CMD_WR;
                3'b010:  cmd = a10 ? CMD_PREA : CMD_PRE;
                3'b001:  cmd = CMD_REF;
                default: cmd = CMD_NOP;
            endcase
        end
        if (cmd == CMD_ACT && $time < free_t[ba]) n_viol++;
        if (cmd == CMD_ACT) act_t[ba] = $time;
        // own precharge waits for row active time, bank busy for tRP after
        if (cmd inside {CMD_RD, CMD_WR} && a10)
            free_t[ba] = ((act_t[ba] + 35 > $time) ? act_t[ba] + 35 : $time) + 14;
        // refresh needs its full cycle before the next one
        if (cmd == CMD_REF && ref_t != 0 && $time - ref_t < 110) n_viol++;
        if (cmd == CMD_REF) ref_t = $time;
    end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import drt_pkg::*;
    logic        clk = 0, rst_n = 0, vld = 0, ap = 0, hot = 0, dll = 0, bc4 = 0, pd = 0;
    drt_cmd_t    rc = CMD_NOP;
    logic [2:0]  bk = 3'h0;
    logic [3:0]  cwl = 4'h5;
    logic        ack, ck, ckn, cke, mr_n, cs_n, ras_n, cas_n, we_n, rhot, idn;
    logic [2:0]  ba;
    logic [13:0] ad;
    logic [3:0]  owed;
    drt_cmd_t    mc;
    time         rt, t0, t1, t2;
    int          nv, n_fail = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    drt_ctrl #(.INIT_RST_CK(8), .INIT_CKE_CK(8)) uut (
        .CLK(clk), .RST_N(rst_n), .REQ_VALID(vld), .REQ_CMD(rc), .REQ_BANK(bk),
        .REQ_ROW(14'h0123), .REQ_COL(10'h000), .REQ_AP(ap), .REQ_ACK(ack),
        .TEMP_HOT(hot), .DLL_OFF(dll), .BC4_FIXED(bc4), .CWL(cwl), .PD_REQ(pd),
        .DDR_CK(ck), .DDR_CK_N(ckn), .DDR_CKE(cke), .DDR_RESET_N(mr_n),
        .DDR_CS_N(cs_n), .DDR_RAS_N(ras_n), .DDR_CAS_N(cas_n), .DDR_WE_N(we_n),
        .DDR_BA(ba), .DDR_ADDR(ad), .REF_OWED(owed), .ROW_HOT(rhot), .INIT_DONE(idn));
    drt_dev_model dev (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .a10(ad[10]), .cmd(mc), .ref_t(rt), .n_viol(nv));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
        samples_checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h..%h", $time, g, lo, hi);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // request held up until acked, valid left high so refresh waits until eight are owed
    task req(input drt_cmd_t c, input logic [2:0] b, input logic a, output time t);
        int i;
        vld = 1;
        rc = c;
        bk = b;
        ap = a;
        i = 0;
        do begin @(posedge clk) #1; i++; end while (ack !== 1'b1 && i < 400);
        chk(ack, 1, 1);
        t = $time;
    endtask
    task wt(input drt_cmd_t c, input int n, output time t);
        int i;
        i = 0;
        do begin @(posedge ck) #1; i++; end while (mc !== c && i < n);
        chk(mc === c, 1, 1);
        t = $time;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task s_init;
        time t;
        chk({mr_n, cke, cs_n}, 1, 1);
        t = $time;
        do @(posedge clk) #1; while (idn !== 1'b1 && $time - t < 1000);
        chk({mr_n, cke}, 3, 3);
        chk(32'(($time - t) / 10), 16, 20);
    endtask
    task s_rows;
        int i;
        req(CMD_ACT, 0, 0, t0);
        chk({ckn, ck, ba, ad}, 32'h40123, 32'h40123);
        req(CMD_PRE, 0, 0, t1);
        chk(32'((t1 - t0) / 10), 4, 5);
        req(CMD_ACT, 1, 0, t0);
        req(CMD_RD, 1, 1, t1);
        chk({ba, ad}, 32'h4400, 32'h4400);
        req(CMD_ACT, 1, 0, t2);
        chk(32'((t2 - t0) / 10), 6, 8);
        req(CMD_PRE, 1, 0, t2);
        for (i = 0; i < 3; i++) begin
            dll = (i > 0);
            bc4 = (i == 2);
            req(CMD_ACT, 2, 0, t0);
            req(CMD_WR, 2, 0, t1);
            req(CMD_PRE, 2, 0, t2);
            chk(32'((t2 - t1) / 10), i == 1 ? 13 : 11, i == 1 ? 14 : 12);
        end
        vld = 0;
    endtask
    task s_hammer;
        int i;
        for (i = 0; i < 64; i++) begin
            req(CMD_ACT, 3, 0, t0);
            req(CMD_PRE, 3, 0, t1);
            if (i == 62) chk(rhot, 0, 0);
        end
        vld = 0;
        chk(rhot, 1, 1);
    endtask
    task s_ref;
        wt(CMD_REF, 2000, t0);
        wt(CMD_REF, 2000, t0);
        wt(CMD_REF, 2000, t1);
        chk(32'((t1 - t0) / 10), 780, 782);
        hot = 1;
        wt(CMD_REF, 2000, t0);
        wt(CMD_REF, 2000, t1);
        chk(32'((t1 - t0) / 10), 389, 391);
        hot = 0;
    endtask
    task s_owed;
        int i;
        vld = 1;
        rc = CMD_NOP;
        for (i = 0; i < 20000 && owed !== 4'h8; i++) @(posedge clk) #1;
        chk(owed, 8, 8);
        wt(CMD_REF, 4, t0);
        chk(owed, 7, 7);
        vld = 0;
    endtask
    task s_pd;
        int i;
        pd = 1;
        for (i = 0; i < 4000 && cke !== 1'b0; i++) @(posedge clk) #1;
        chk(32'($time - rt), 146, 200);
        chk(owed, 0, 0);
        pd = 0;
        for (i = 0; i < 100 && cke !== 1'b1; i++) @(posedge clk) #1;
        chk(cke, 1, 1);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        s_init;
        s_rows;
        s_hammer;
        s_ref;
        s_owed;
        s_pd;
        chk(nv, 0, 0);
        final_report;
    end
    initial begin
        #400000;
        n_fail++;
        final_report;
    end
endmodule
